// *** pie_pkg.sv ***
/*
  Package for the peripheral interrupt enable and flag block: register
  offsets, bit positions, reset values and the peripheral event carrier.
  Assumes a 32-bit classic Wishbone slave with one register per word.
*/
package pie_pkg;

  // Register byte offsets
  localparam logic [7:0] PIE_OFF_ENABLE_ONE = 8'h00;
  localparam logic [7:0] PIE_OFF_ENABLE_TWO = 8'h04;
  localparam logic [7:0] PIE_OFF_REQUEST_ONE = 8'h08;
  localparam logic [7:0] PIE_OFF_REQUEST_TWO = 8'h0c;
  localparam logic [7:0] PIE_OFF_INT_CONTROL = 8'h10;
  localparam logic [7:0] PIE_OFF_RX_DATA = 8'h14;
  localparam logic [7:0] PIE_OFF_TX_DATA = 8'h18;

  // Bit positions in the enable and request registers; unit two is in the second pair
  localparam int PIE_BIT_T1_GATE = 7;
  localparam int PIE_BIT_ADC = 6;
  localparam int PIE_BIT_RX = 5;
  localparam int PIE_BIT_TX = 4;
  localparam int PIE_BIT_SYNC = 3;
  localparam int PIE_BIT_CAPCMP_ONE = 2;
  localparam int PIE_BIT_T2_MATCH = 1;
  localparam int PIE_BIT_T1_OVERFLOW = 0;
  localparam int PIE_BIT_CAPCMP_TWO = 0;

  // Bit positions in the interrupt control register
  localparam int PIE_BIT_GLOBAL = 7;
  localparam int PIE_BIT_GROUP = 6;

  // Reset values
  localparam logic [7:0] PIE_RST_ENABLE = 8'h00;
  localparam logic [7:0] PIE_RST_REQUEST = 8'h00;
  localparam logic [1:0] PIE_RST_CONTROL = 2'h0;

  // Sticky flags in the first request register (set by hw, cleared by sw)
  localparam logic [7:0] PIE_STICKY_MASK = 8'h4f;

  // Capture/compare unit modes
  typedef enum logic [1:0]
  {
    PIE_CC_CAPTURE = 2'h0,
    PIE_CC_COMPARE = 2'h1,
    PIE_CC_PWM = 2'h2
  } pie_cc_mode_t;

  // Conditions reported by the on-chip peripherals (same clock)
  typedef struct packed
  {
    logic t1_gate_active;   // Level: gate acquisition active
    logic adc_done;         // Pulse: conversion complete
    logic rx_full;          // Level: receive buffer full
    logic tx_empty;         // Level: transmit buffer empty
    logic sync_done;        // Pulse: serial transfer complete
    logic cc_one_capture;   // Pulse: unit one captured
    logic cc_one_match;     // Pulse: unit one compare match
    logic t2_match;         // Pulse: timer2 matched period
    logic t1_overflow;      // Pulse: timer1 overflow
    logic cc_two_capture;   // Pulse: unit two captured
    logic cc_two_match;     // Pulse: unit two compare match
  } pie_events_t;

endpackage : pie_pkg

// *** pie_wb_slave.sv ***
/*
  Classic Wishbone slave front end: latches the byte address and produces
  one-cycle read and write strobes plus a registered ack.
  Assumes a master that holds its request until ack and then drops cyc.
*/
`timescale 1ns/1ps
module pie_wb_slave
  import pie_pkg::*;
(
  input wire logic clk_i,          // System clock
  input wire logic rst_i,          // Synchronous reset
  input wire logic cyc_i,          // Bus cycle
  input wire logic stb_i,          // Strobe
  input wire logic we_i,           // Write enable
  input wire logic [3:0] sel_i,    // Byte selects
  input wire logic [7:0] adr_i,    // Byte address
  output logic ack_o,              // Registered ack
  output logic wr_o,               // Write strobe, one cycle
  output logic rd_o,               // Read strobe, one cycle
  output logic [7:0] adr_o         // Latched address
);

  logic req;

  // Answer only once per request; ack drops the cycle after it rose
  assign req = cyc_i & stb_i & ~ack_o;

  // Ack and strobes come one edge after the request is seen
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      adr_o <= 8'h00;
    end
    else
    begin
      ack_o <= req;
      wr_o <= req & we_i & sel_i[0]; // Only the low lane holds data
      rd_o <= req & ~we_i;
      adr_o <= adr_i;
    end
  end

endmodule // pie_wb_slave

// *** pie_flag_bit.sv ***
/*
  One sticky request flag: a hardware set that wins over a software clear.
  Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
module pie_flag_bit
  import pie_pkg::*;
(
  input wire logic clk_i,   // System clock
  input wire logic rst_i,   // Synchronous reset
  input wire logic set_i,   // Hardware event
  input wire logic wr_i,    // Software write to this flag
  input wire logic wdat_i,  // Written value
  output logic flag_o       // Flag state
);

  // Set wins so an event in the clearing cycle is kept
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_o <= PIE_RST_REQUEST[0];
    else if (set_i)
      flag_o <= 1'b1;
    else if (wr_i)
      flag_o <= wdat_i;
  end

endmodule // pie_flag_bit

// *** pie_irq_ctrl.sv ***
/*
  Peripheral interrupt enable and request flag block with Wishbone access.
  Holds both enable registers, both request registers and the two gate
  bits of the interrupt control register, and drives one combined
  request towards the processor.
  Assumes peripherals report events on clk_i and hold levels themselves;
  software owns enables, sticky flags and the two gate bits, and services
  the serial buffers through the two strobe offsets.
*/
// Functional notes
// - No peripheral request passes unless the group enable bit is set.
// - Flags set on their condition regardless of any enable bit.
// - Enable bits are read/write, reset to zero, one enables.
// - Bit 7 flag reads one while timer1 gate inactive.
// - Bit 6 flag sets on conversion done, held until software clears.
// - Bit 5 flag read-only, full receive buffer, cleared by data read.
// - Bit 4 flag read-only, empty transmit buffer, cleared by data write.
// - Bit 3 flag sets on serial transfer done, software clears.
// - Bit 2 flag sets on capture or match per mode, unused in pwm.
// - Bit 1 flag sets on timer2 period match, software clears.
// - Bit 0 flag sets on timer1 overflow, software clears.
// - Second enable register has only bit 0; others read zero.
// - Second flag register has only bit 0, unit two events.
// - Global enable bit 7 must be one for any interrupt.
`timescale 1ns/1ps
module pie_irq_ctrl
  import pie_pkg::*;
(
  input wire logic clk_i,               // System clock, 25 MHz
  input wire logic rst_i,               // Synchronous reset
  input wire logic cyc_i,               // Wishbone cycle
  input wire logic stb_i,               // Wishbone strobe
  input wire logic we_i,                // Wishbone write enable
  input wire logic [3:0] sel_i,         // Wishbone byte selects
  input wire logic [7:0] adr_i,         // Wishbone byte address
  input wire logic [31:0] dat_i,        // Wishbone write data
  output logic [31:0] dat_o,            // Wishbone read data
  output logic ack_o,                   // Wishbone ack
  input wire pie_events_t events_i,     // Peripheral conditions
  input wire pie_cc_mode_t cc_one_mode_i, // Unit one mode
  input wire pie_cc_mode_t cc_two_mode_i, // Unit two mode
  output logic rx_data_read_o,          // Pulse: receive data read
  output logic tx_data_write_o,         // Pulse: transmit data written
  output logic periph_irq_o             // Request to the processor
);

  // Register bus side
  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_adr;
  logic [7:0] peripheral_enable_one;
  logic peripheral_enable_two;
  logic global_irq_enable;
  logic periph_group_enable;
  logic [7:0] peripheral_request_one;
  logic peripheral_request_two;
  logic [7:0] flag_set_one;
  logic [7:0] wdat;
  logic wr_enable_one;
  logic wr_enable_two;
  logic wr_request_one;
  logic wr_request_two;
  logic wr_control;
  logic any_pending;
  logic next_irq;
  logic [31:0] next_rdata;
  // Flag sources and request masking
  logic flag_set_two;
  logic [7:0] status_in;
  logic [7:0] masked_one;
  logic masked_two;
  logic rd_rx_data;
  logic wr_tx_data;

  // Bus front end; ack comes one edge after the request is seen
  // and drops again at the next edge
  pie_wb_slave u_bus
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .sel_i(sel_i),
    .adr_i(adr_i),
    .ack_o(ack_o),
    .wr_o(bus_wr),
    .rd_o(bus_rd),
    .adr_o(bus_adr)
  );

  // Write data is latched with the request so it matches the strobe;
  // holding it between requests keeps it stable while the strobe acts
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wdat <= 8'h00;
    else if (cyc_i & stb_i & ~ack_o)
      wdat <= dat_i[7:0];
  end

  // Write decodes; an unmapped offset writes nothing, and a write with
  // the low byte lane off never raises the strobe
  assign wr_enable_one = bus_wr & (bus_adr == PIE_OFF_ENABLE_ONE);
  assign wr_enable_two = bus_wr & (bus_adr == PIE_OFF_ENABLE_TWO);
  assign wr_request_one = bus_wr & (bus_adr == PIE_OFF_REQUEST_ONE);
  assign wr_request_two = bus_wr & (bus_adr == PIE_OFF_REQUEST_TWO);
  assign wr_control = bus_wr & (bus_adr == PIE_OFF_INT_CONTROL);

  // First enable register: plain read/write, cleared on reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      peripheral_enable_one <= PIE_RST_ENABLE;
    else if (wr_enable_one)
      peripheral_enable_one <= wdat;
  end

  // Second enable register: only the unit two bit is stored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      peripheral_enable_two <= PIE_RST_ENABLE[0];
    else if (wr_enable_two)
      peripheral_enable_two <= wdat[PIE_BIT_CAPCMP_TWO];
  end

  // Only the two gate bits of the control register live here; the
  // other bits belong to sources outside this block and read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      global_irq_enable <= PIE_RST_CONTROL[1];
      periph_group_enable <= PIE_RST_CONTROL[0];
    end
    else if (wr_control)
    begin
      global_irq_enable <= wdat[PIE_BIT_GLOBAL];
      periph_group_enable <= wdat[PIE_BIT_GROUP];
    end
  end

  // Event sources for the sticky flags, independent of any enable
  always_comb
  begin
    flag_set_one = 8'h00;
    flag_set_one[PIE_BIT_ADC] = events_i.adc_done;
    flag_set_one[PIE_BIT_SYNC] = events_i.sync_done;
    // Pwm mode leaves the flag untouched
    flag_set_one[PIE_BIT_CAPCMP_ONE] =
      ((cc_one_mode_i == PIE_CC_CAPTURE) & events_i.cc_one_capture) |
      ((cc_one_mode_i == PIE_CC_COMPARE) & events_i.cc_one_match);
    flag_set_one[PIE_BIT_T2_MATCH] = events_i.t2_match;
    flag_set_one[PIE_BIT_T1_OVERFLOW] = events_i.t1_overflow;
  end

  // Unit two follows the same mode rule as unit one
  always_comb
  begin
    flag_set_two =
      ((cc_two_mode_i == PIE_CC_CAPTURE) & events_i.cc_two_capture) |
      ((cc_two_mode_i == PIE_CC_COMPARE) & events_i.cc_two_match);
  end

  // Levels for the status-following flags; the gate flag is inverted
  // because it reports an idle gate, not an active one
  always_comb
  begin
    status_in = 8'h00;
    status_in[PIE_BIT_T1_GATE] = ~events_i.t1_gate_active;
    status_in[PIE_BIT_RX] = events_i.rx_full;
    status_in[PIE_BIT_TX] = events_i.tx_empty;
  end

  // One request flag per bit of the first request register: sticky bits
  // are held until software writes them, status bits follow the source
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_flag
      if (PIE_STICKY_MASK[gi])
      begin : g_sticky
        logic flag;
        // Software-cleared flag; an event in the clearing cycle wins
        pie_flag_bit u_flag
        (
          .clk_i(clk_i),
          .rst_i(rst_i),
          .set_i(flag_set_one[gi]),
          .wr_i(wr_request_one),
          .wdat_i(wdat[gi]),
          .flag_o(flag)
        );
        assign peripheral_request_one[gi] = flag;
      end
      else
      begin : g_status
        logic status;
        // Registered so status bits line up with the sticky bits;
        // writes are ignored, so these bits are read-only to software
        always_ff @(posedge clk_i)
        begin
          if (rst_i)
            status <= PIE_RST_REQUEST[gi];
          else
            status <= status_in[gi];
        end
        assign peripheral_request_one[gi] = status;
      end
    end
  endgenerate

  // Unit two flag in the second request register; bits 7 to 1 are
  // not stored and read zero
  pie_flag_bit u_flag_two
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(flag_set_two),
    .wr_i(wr_request_two),
    .wdat_i(wdat[PIE_BIT_CAPCMP_TWO]),
    .flag_o(peripheral_request_two)
  );

  // Side-effect strobes to the serial port, which clears its own buffer
  // state; they come from the latched access, one edge after ack, so the
  // flag they clear drops a few cycles after the access completes
  assign rd_rx_data = bus_rd & (bus_adr == PIE_OFF_RX_DATA);
  assign wr_tx_data = bus_wr & (bus_adr == PIE_OFF_TX_DATA);

  // Receive buffer consumed
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_data_read_o <= 1'b0;
    else
      rx_data_read_o <= rd_rx_data;
  end

  // Transmit buffer loaded
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tx_data_write_o <= 1'b0;
    else
      tx_data_write_o <= wr_tx_data;
  end

  // Combined request: each flag is masked by its own enable first, then
  // the group gate, then the global gate.
  // Software is expected to clear a flag before enabling it.
  assign masked_one = peripheral_request_one & peripheral_enable_one;
  assign masked_two = peripheral_request_two & peripheral_enable_two;
  assign any_pending = (|masked_one) | masked_two;
  assign next_irq = any_pending & periph_group_enable
                    & global_irq_enable;

  // Registered so the processor never sees a decode glitch
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      periph_irq_o <= 1'b0;
    else
      periph_irq_o <= next_irq;
  end

  // Read mux; unmapped and unimplemented bits read zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (adr_i)
      PIE_OFF_ENABLE_ONE: next_rdata[7:0] = peripheral_enable_one;
      PIE_OFF_ENABLE_TWO: next_rdata[0] = peripheral_enable_two;
      PIE_OFF_REQUEST_ONE: next_rdata[7:0] = peripheral_request_one;
      PIE_OFF_REQUEST_TWO: next_rdata[0] = peripheral_request_two;
      // Strobe offsets have no storage
      PIE_OFF_RX_DATA, PIE_OFF_TX_DATA: next_rdata = 32'h0000_0000;
      PIE_OFF_INT_CONTROL:
      begin
        next_rdata[PIE_BIT_GLOBAL] = global_irq_enable;
        next_rdata[PIE_BIT_GROUP] = periph_group_enable;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data registered alongside ack
  // and held until the next read is taken
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (cyc_i & stb_i & ~we_i & ~ack_o)
      dat_o <= next_rdata;
  end

endmodule // pie_irq_ctrl

// *** pie_irq_ctrl_monitor.sv ***
/*
  Port checker for the interrupt enable and flag block.
  Assumes one clock and a bus master that holds requests until ack.
*/
`timescale 1ns/1ps
module pie_irq_ctrl_monitor
  import pie_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic cyc_i, // Bus cycle
  input wire logic stb_i, // Bus strobe
  input wire logic we_i, // Write enable
  input wire logic [3:0] sel_i, // Byte selects
  input wire logic [7:0] adr_i, // Byte address
  input wire logic [31:0] dat_i, // Write data
  input wire logic [31:0] dat_o, // Read data
  input wire logic ack_o, // Bus ack
  input wire pie_events_t events_i, // Peripheral conditions
  input wire pie_cc_mode_t cc_one_mode_i, // Unit one mode
  input wire pie_cc_mode_t cc_two_mode_i, // Unit two mode
  input wire logic rx_data_read_o, // Receive data read
  input wire logic tx_data_write_o, // Transmit data written
  input wire logic periph_irq_o // Request out
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic grp;
  logic glb;
  logic ctl_wr;
  logic req;
  // Shadow of the two gate bits, taken at the edge a write lands
  assign req = cyc_i & stb_i & ~ack_o;
  assign ctl_wr = cyc_i & stb_i & ack_o & we_i & sel_i[0]
    & (adr_i == PIE_OFF_INT_CONTROL);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      grp <= 1'b0;
      glb <= 1'b0;
    end
    else if (ctl_wr)
    begin
      grp <= dat_i[PIE_BIT_GROUP];
      glb <= dat_i[PIE_BIT_GLOBAL];
    end
  end
  property p_ack_once;
    ack_o |=> !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held");
  property p_ack_answer;
    req |=> ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack");
  property p_dat_upper;
    ack_o |-> dat_o[31:8] == 24'h0;
  endproperty
  a_dat_upper: assert property (p_dat_upper) else $error("upper data");
  property p_rx_strobe;
    req && !we_i && adr_i == PIE_OFF_RX_DATA |-> ##[1:2] rx_data_read_o;
  endproperty
  a_rx_strobe: assert property (p_rx_strobe) else $error("rx strobe");
  property p_tx_strobe;
    req && we_i && sel_i[0] && adr_i == PIE_OFF_TX_DATA
      |-> ##[1:2] tx_data_write_o;
  endproperty
  a_tx_strobe: assert property (p_tx_strobe) else $error("tx strobe");
  property p_group_gate;
    !grp |=> !periph_irq_o;
  endproperty
  a_group_gate: assert property (p_group_gate) else $error("group");
  property p_global_gate;
    !glb |=> !periph_irq_o;
  endproperty
  a_global_gate: assert property (p_global_gate) else $error("glb");
  property p_reset_quiet;
    $fell(rst_i) |-> !periph_irq_o && !ack_o;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("reset out");
  c_irq: cover property (periph_irq_o);
  c_rx: cover property (rx_data_read_o);
  c_tx: cover property (tx_data_write_o);
endmodule // pie_irq_ctrl_monitor

bind pie_irq_ctrl pie_irq_ctrl_monitor u_pie_irq_ctrl_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .events_i(events_i),
  .cc_one_mode_i(cc_one_mode_i), .cc_two_mode_i(cc_two_mode_i),
  .rx_data_read_o(rx_data_read_o), .tx_data_write_o(tx_data_write_o),
  .periph_irq_o(periph_irq_o));

// *** pie_periph_model.sv ***
/*
  Peripheral stand-in: passes event pulses, keeps buffer levels.
  Assumes the bench drives ev_i just after clk_i edges.
*/
`timescale 1ns/1ps
module pie_periph_model
  import pie_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire pie_events_t ev_i, // Requested conditions
  input wire logic rx_data_read_i, // Receive data consumed
  input wire logic tx_data_write_i, // Transmit data loaded
  output pie_events_t events_o // Conditions to the block
);
  logic rx_full;
  logic tx_empty;
  // Levels hold until software services the buffer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_full <= 1'b0;
      tx_empty <= 1'b0;
    end
    else
    begin
      rx_full <= (rx_full | ev_i.rx_full) & ~rx_data_read_i;
      tx_empty <= (tx_empty | ev_i.tx_empty) & ~tx_data_write_i;
    end
  end
  // Pulses and the gate level pass straight through
  always_comb
  begin
    events_o = ev_i;
    events_o.rx_full = rx_full;
    events_o.tx_empty = tx_empty;
  end
endmodule // pie_periph_model

// *** testbench.sv ***
/*
  Self-checking bench for the interrupt enable and flag block.
  Assumes the one-cycle ack and register map of the package.
*/
`timescale 1ns/1ps
module testbench
  import pie_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic ack;
  logic rxr;
  logic txw;
  logic irq;
  pie_events_t ev = '0;
  pie_events_t evd;
  pie_cc_mode_t m1 = PIE_CC_CAPTURE;
  pie_cc_mode_t m2 = PIE_CC_CAPTURE;
  int mismatches = 0;
  int comparisons = 0;
  logic [31:0] q;

  always #20 clk_i = ~clk_i;

  pie_periph_model u_pie_periph_model (.clk_i(clk_i), .rst_i(rst_i),
    .ev_i(ev), .rx_data_read_i(rxr), .tx_data_write_i(txw),
    .events_o(evd));
  pie_irq_ctrl u_pie_irq_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .sel_i(sel), .adr_i(adr), .dat_i(dat_w),
    .dat_o(dat_r), .ack_o(ack), .events_i(evd), .cc_one_mode_i(m1),
    .cc_two_mode_i(m2), .rx_data_read_o(rxr), .tx_data_write_o(txw),
    .periph_irq_o(irq));

  task automatic check(input logic [31:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== {24'h0, exp})
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; waits for ack, released at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    dat_w <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
    if (ack !== 1'b1)
    begin
      mismatches++;
      $display("unexpected at %0t: ack %h expected %h", $time, ack, 1'b1);
    end
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic pulse(input pie_events_t e);
    @(posedge clk_i);
    ev <= e;
    @(posedge clk_i);
    ev <= '0;
  endtask

  task automatic t_reset();
    logic [7:0] exp [5] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++)
    begin
      wb(1'b0, 8'(4 * i), 8'h00);
      check(q, exp[i]);
    end
    wb(1'b0, 8'h1c, 8'h00);
    check(q, 8'h00);
  endtask

  task automatic t_enables();
    wb(1'b1, PIE_OFF_ENABLE_ONE, 8'hff);
    wb(1'b0, PIE_OFF_ENABLE_ONE, 8'h00);
    check(q, 8'hff);
    wb(1'b1, PIE_OFF_ENABLE_TWO, 8'hff);
    wb(1'b0, PIE_OFF_ENABLE_TWO, 8'h00);
    check(q, 8'h01);
    wb(1'b1, PIE_OFF_ENABLE_ONE, 8'h00);
    wb(1'b1, PIE_OFF_ENABLE_TWO, 8'h00);
    ev.t1_gate_active <= 1'b1;
    wb(1'b0, PIE_OFF_REQUEST_ONE, 8'h00);
    check(q, 8'h00);
    ev.t1_gate_active <= 1'b0;
  endtask

  // Sticky flags set with every enable off, then cleared
  task automatic t_sticky();
    pie_events_t e;
    int b [4] = '{6, 3, 1, 0};
    for (int i = 0; i < 4; i++)
    begin
      e = '0;
      case (i)
        0: e.adc_done = 1'b1;
        1: e.sync_done = 1'b1;
        2: e.t2_match = 1'b1;
        default: e.t1_overflow = 1'b1;
      endcase
      pulse(e);
      repeat (3) @(posedge clk_i);
      wb(1'b0, PIE_OFF_REQUEST_ONE, 8'h00);
      check(q, 8'h80 | 8'(1 << b[i]));
      wb(1'b1, PIE_OFF_REQUEST_ONE, 8'h00);
      wb(1'b0, PIE_OFF_REQUEST_ONE, 8'h00);
      check(q, 8'h80);
    end
  endtask

  task automatic t_capcmp();
    pie_events_t e;
    for (int m = 0; m < 3; m++)
    begin
      for (int k = 0; k < 2; k++)
      begin
        m1 <= pie_cc_mode_t'(m);
        m2 <= pie_cc_mode_t'(m);
        e = '0;
        e.cc_one_capture = (k == 0);
        e.cc_two_capture = (k == 0);
        e.cc_one_match = (k == 1);
        e.cc_two_match = (k == 1);
        pulse(e);
        wb(1'b0, PIE_OFF_REQUEST_ONE, 8'h00);
        check(q, (m == k) ? 8'h84 : 8'h80);
        wb(1'b0, PIE_OFF_REQUEST_TWO, 8'h00);
        check(q, (m == k) ? 8'h01 : 8'h00);
        wb(1'b1, PIE_OFF_REQUEST_ONE, 8'h00);
        wb(1'b1, PIE_OFF_REQUEST_TWO, 8'h00);
      end
    end
  endtask

  task automatic t_buffers();
    pie_events_t e;
    e = '0;
    e.rx_full = 1'b1;
    e.tx_empty = 1'b1;
    pulse(e);
    wb(1'b1, PIE_OFF_REQUEST_ONE, 8'h00);
    wb(1'b0, PIE_OFF_REQUEST_ONE, 8'h00);
    check(q, 8'hb0);
    wb(1'b0, PIE_OFF_RX_DATA, 8'h00);
    repeat (3) @(posedge clk_i);
    wb(1'b0, PIE_OFF_REQUEST_ONE, 8'h00);
    check(q, 8'h90);
    wb(1'b1, PIE_OFF_TX_DATA, 8'h5a);
    repeat (3) @(posedge clk_i);
    wb(1'b0, PIE_OFF_REQUEST_ONE, 8'h00);
    check(q, 8'h80);
  endtask

  // Flag cleared before its enable is set, then each gate toggled
  task automatic t_irq();
    pie_events_t e;
    logic [7:0] ctl [3] = '{8'h80, 8'hc0, 8'h40};
    e = '0;
    e.t2_match = 1'b1;
    wb(1'b1, PIE_OFF_REQUEST_ONE, 8'h00);
    wb(1'b1, PIE_OFF_ENABLE_ONE, 8'h02);
    pulse(e);
    for (int i = 0; i < 3; i++)
    begin
      wb(1'b1, PIE_OFF_INT_CONTROL, ctl[i]);
      repeat (3) @(posedge clk_i);
      check({31'h0, irq}, (i == 1) ? 8'h01 : 8'h00);
    end
  endtask

  // Request raised, then a mid-run reset clears enables, gates and request
  task automatic t_rerun();
    wb(1'b1, PIE_OFF_ENABLE_ONE, 8'h5a);
    wb(1'b1, PIE_OFF_INT_CONTROL, 8'hc0);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq}, 8'h01);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, PIE_OFF_ENABLE_ONE, 8'h00);
    check(q, 8'h00);
    wb(1'b0, PIE_OFF_INT_CONTROL, 8'h00);
    check(q, 8'h00);
    check({31'h0, irq}, 8'h00);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_enables();
    t_sticky();
    t_capcmp();
    t_buffers();
    t_irq();
    t_rerun();
    print_verdict();
  end

  // Whole run needs well under ten thousand cycles
  initial
  begin
    #400000;
    mismatches++;
    print_verdict();
  end
endmodule // testbench
